/* File: common/scx_pkg.sv */
// Package for the system-control instruction executor.
// Assumes one 50 MHz system clock and an external decoder that classifies opcodes.
package scx_pkg;

  localparam int unsigned PC_W      = 12;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned SP_W      = 8;
  localparam int unsigned CLK_MHZ   = 50;
  // Least hold of the software reset pulse, in ns, and its count of cycles
  localparam int unsigned SWRST_NS  = 40;
  localparam int unsigned SWRST_CYC = (SWRST_NS * CLK_MHZ + 999) / 1000;
  localparam logic [PC_W-1:0]   PC_RST  = 12'h000;
  localparam logic [SP_W-1:0]   SP_RST  = 8'h00;
  localparam logic [SP_W-1:0]   SP_STEP = 8'h02;
  localparam logic [PC_W-1:0]   PC_STEP = 12'h001;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;

  // Instruction classes of the system-control group
  typedef enum logic [3:0] {
    SCX_OP_NONE   = 4'h0,
    SCX_OP_CALL   = 4'h1,
    SCX_OP_GOTO   = 4'h2,
    SCX_OP_RETI   = 4'h3,
    SCX_OP_RET    = 4'h4,
    SCX_OP_RETIMM = 4'h5,
    SCX_OP_PCADD  = 4'h6,
    SCX_OP_NOP    = 4'h7,
    SCX_OP_EI     = 4'h8,
    SCX_OP_DI     = 4'h9,
    SCX_OP_HALTSYS= 4'hA,
    SCX_OP_HALTCPU= 4'hB,
    SCX_OP_SWRST  = 4'hC,
    SCX_OP_WDRST  = 4'hD
  } scx_op_t;

  // One decoded instruction
  typedef struct packed {
    scx_op_t           op;
    logic [PC_W-1:0]   target;
    logic [DATA_W-1:0] imm;
  } scx_instr_t;

  // Stack memory write/read request
  typedef struct packed {
    logic            wr;
    logic            rd;
    logic [SP_W-1:0] addr;
    logic [PC_W-1:0] wdata;
  } scx_stack_t;

  // Execution states, one-hot
  typedef enum logic [3:0] {
    SCX_ST_RUN  = 4'b0001,
    SCX_ST_RET  = 4'b0010,
    SCX_ST_HALT = 4'b0100,
    SCX_ST_RST  = 4'b1000
  } scx_state_t;

endpackage : scx_pkg

/* File: core/scx_rst_stretch.sv */
// Pulse stretcher for the software-triggered chip reset.
// Assumes a synchronous trigger on the system clock.
`timescale 1ns/1ps
module scx_rst_stretch #(
  parameter int unsigned CYCLES = scx_pkg::SWRST_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic trig_i,
  output logic      rst_o
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       rst_q;
  logic       rst_d;

  // Load on trigger, count down to release
  always_comb begin
    cnt_d = cnt_q;
    if (trig_i) begin
      cnt_d = 8'(CYCLES);
    end else if (cnt_q != 8'h00) begin
      cnt_d = cnt_q - 8'h01;
    end
    rst_d = (cnt_d != 8'h00);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
      rst_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      rst_q <= rst_d;
    end
  end

  assign rst_o = rst_q;
endmodule : scx_rst_stretch

/* File: core/scx_exec.sv */
// Execution logic for the system-control instruction group.
// Assumes a decoder presents one instruction per cycle with instr_valid_i,
// and a stack RAM answering reads in the same cycle as the request.
// Summary of operation
// RQ1: Call pushes pc+1, jumps, stack pointer plus two
// RQ2: Jump loads full-range target address
// RQ3: Return-with-value loads accumulator, then returns
// RQ4: Return: stack pointer minus two, reload pc
// RQ5: Interrupt return also sets global interrupt enable
// RQ6: Computed jump adds unsigned accumulator to pc
// RQ7: Enable instruction sets global interrupt enable
// RQ8: Disable instruction clears global interrupt enable
// RQ9: Full halt stops all clocks and oscillators
// RQ10: Core halt gates core clock, oscillators run
// RQ11: Software reset acts like hardware reset, except that flags_o is not cleared and keeps following flags_i
// RQ12: Watchdog restart clears watchdog count
// RQ13: No flag changes; nop only advances pc
// RQ14: Halted until wake-up or reset, then resume
// RQ15: Each return address uses two stack bytes
`timescale 1ns/1ps
module scx_exec #(
  parameter int unsigned PC_W   = scx_pkg::PC_W,
  parameter int unsigned DATA_W = scx_pkg::DATA_W,
  parameter int unsigned SP_W   = scx_pkg::SP_W
) (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_i,
  input  wire logic                 instr_valid_i,
  input  wire scx_pkg::scx_instr_t  instr_i,
  input  wire logic [DATA_W-1:0]    acc_i,
  input  wire logic [PC_W-1:0]      stack_rdata_i,
  input  wire logic                 wake_i,
  input  wire logic [3:0]           flags_i,
  output logic [PC_W-1:0]           program_counter_o,
  output logic [SP_W-1:0]           stack_pointer_o,
  output logic [DATA_W-1:0]         accumulator_o,
  output logic                      acc_we_o,
  output logic [3:0]                flags_o,
  output logic                      gint_en_o,
  output scx_pkg::scx_stack_t       stack_o,
  output logic                      busy_o,
  output logic                      osc_stop_o,
  output logic                      core_clk_gate_o,
  output logic                      wdt_clear_o,
  output logic                      chip_rst_o
);
  scx_pkg::scx_state_t st_q, st_d;
  logic [PC_W-1:0]     pc_q, pc_d;
  logic [SP_W-1:0]     sp_q, sp_d;
  logic [DATA_W-1:0]   acc_q, acc_d;
  logic                acc_we_q, acc_we_d;
  logic                gie_q, gie_d;
  logic                gie_ret_q, gie_ret_d;
  scx_pkg::scx_stack_t stk_q, stk_d;
  logic                osc_q, osc_d;
  logic                gate_q, gate_d;
  logic                wdc_q, wdc_d;
  logic                swr_trig_q, swr_trig_d;
  logic                chip_rst;
  logic                go;
  logic                busy_q, busy_d;

  assign go = instr_valid_i && (st_q == scx_pkg::SCX_ST_RUN);

  // Next-state and datapath for every system-control class
  always_comb begin
    st_d       = st_q;
    pc_d       = pc_q;
    sp_d       = sp_q;
    acc_d      = acc_q;
    acc_we_d   = 1'b0;
    gie_d      = gie_q;
    gie_ret_d  = 1'b0;
    stk_d      = '0;
    osc_d      = osc_q;
    gate_d     = gate_q;
    wdc_d      = 1'b0;
    swr_trig_d = 1'b0;
    case (st_q)
      scx_pkg::SCX_ST_RUN: begin
        if (go) begin
          case (instr_i.op)
            scx_pkg::SCX_OP_CALL: begin
              stk_d.wr    = 1'b1;                          // RQ1
              stk_d.addr  = sp_q;                          // RQ15
              stk_d.wdata = pc_q + scx_pkg::PC_STEP;       // RQ1
              pc_d        = instr_i.target;                // RQ1
              sp_d        = sp_q + scx_pkg::SP_STEP;       // RQ1 RQ15
            end
            scx_pkg::SCX_OP_GOTO: pc_d = instr_i.target;   // RQ2
            scx_pkg::SCX_OP_RET, scx_pkg::SCX_OP_RETI, scx_pkg::SCX_OP_RETIMM: begin
              if (instr_i.op == scx_pkg::SCX_OP_RETIMM) begin
                acc_d    = instr_i.imm;                    // RQ3
                acc_we_d = 1'b1;                           // RQ3
              end
              sp_d       = sp_q - scx_pkg::SP_STEP;        // RQ4
              stk_d.rd   = 1'b1;                           // RQ4
              stk_d.addr = sp_q - scx_pkg::SP_STEP;        // RQ4 RQ15
              gie_ret_d  = (instr_i.op == scx_pkg::SCX_OP_RETI); // RQ5
              st_d       = scx_pkg::SCX_ST_RET;
            end
            scx_pkg::SCX_OP_PCADD: pc_d = pc_q + PC_W'(acc_i); // RQ6
            scx_pkg::SCX_OP_EI: begin
              gie_d = 1'b1;                                // RQ7
              pc_d  = pc_q + scx_pkg::PC_STEP;
            end
            scx_pkg::SCX_OP_DI: begin
              gie_d = 1'b0;                                // RQ8
              pc_d  = pc_q + scx_pkg::PC_STEP;
            end
            scx_pkg::SCX_OP_HALTSYS: begin
              osc_d  = 1'b1;                               // RQ9
              gate_d = 1'b1;                               // RQ9
              pc_d   = pc_q + scx_pkg::PC_STEP;            // RQ14
              st_d   = scx_pkg::SCX_ST_HALT;
            end
            scx_pkg::SCX_OP_HALTCPU: begin
              gate_d = 1'b1;                               // RQ10
              pc_d   = pc_q + scx_pkg::PC_STEP;            // RQ14
              st_d   = scx_pkg::SCX_ST_HALT;
            end
            scx_pkg::SCX_OP_SWRST: begin
              swr_trig_d = 1'b1;                           // RQ11
              st_d       = scx_pkg::SCX_ST_RST;
            end
            scx_pkg::SCX_OP_WDRST: begin
              wdc_d = 1'b1;                                // RQ12
              pc_d  = pc_q + scx_pkg::PC_STEP;
            end
            default: pc_d = pc_q + scx_pkg::PC_STEP;       // RQ13
          endcase
        end
      end
      scx_pkg::SCX_ST_RET: begin
        pc_d = stack_rdata_i;                              // RQ4
        if (gie_ret_q) begin
          gie_d = 1'b1;                                    // RQ5
        end
        st_d = scx_pkg::SCX_ST_RUN;
      end
      scx_pkg::SCX_ST_HALT: begin
        if (wake_i) begin
          osc_d  = 1'b0;                                   // RQ14
          gate_d = 1'b0;                                   // RQ14
          st_d   = scx_pkg::SCX_ST_RUN;
        end
      end
      scx_pkg::SCX_ST_RST: st_d = scx_pkg::SCX_ST_RST;     // Held until reset lands
      default: st_d = scx_pkg::SCX_ST_RUN;
    endcase
    // Registered so busy_o leaves a flip-flop, same timing as the state
    busy_d = (st_d != scx_pkg::SCX_ST_RUN);
  end

  // Software reset stretched so every chip register sees it
  scx_rst_stretch #(
    .CYCLES (scx_pkg::SWRST_CYC)
  ) u_swrst (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .trig_i    (swr_trig_q),
    .rst_o     (chip_rst)
  );

  // Chip reset also clears this block: same effect as hardware reset
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_q       <= scx_pkg::SCX_ST_RUN;
      pc_q       <= scx_pkg::PC_RST;
      sp_q       <= scx_pkg::SP_RST;
      acc_q      <= scx_pkg::ACC_RST;
      acc_we_q   <= 1'b0;
      gie_q      <= 1'b0;
      gie_ret_q  <= 1'b0;
      stk_q      <= '0;
      osc_q      <= 1'b0;
      gate_q     <= 1'b0;
      wdc_q      <= 1'b0;
      swr_trig_q <= 1'b0;
      busy_q     <= 1'b0;
    end else if (chip_rst) begin
      st_q       <= scx_pkg::SCX_ST_RUN;                   // RQ11
      pc_q       <= scx_pkg::PC_RST;                       // RQ11
      sp_q       <= scx_pkg::SP_RST;
      acc_q      <= scx_pkg::ACC_RST;
      acc_we_q   <= 1'b0;
      gie_q      <= 1'b0;
      gie_ret_q  <= 1'b0;
      stk_q      <= '0;
      osc_q      <= 1'b0;
      gate_q     <= 1'b0;
      wdc_q      <= 1'b0;
      swr_trig_q <= 1'b0;
      busy_q     <= 1'b0;
    end else begin
      st_q       <= st_d;
      pc_q       <= pc_d;
      sp_q       <= sp_d;
      acc_q      <= acc_d;
      acc_we_q   <= acc_we_d;
      gie_q      <= gie_d;
      gie_ret_q  <= gie_ret_d;
      stk_q      <= stk_d;
      osc_q      <= osc_d;
      gate_q     <= gate_d;
      wdc_q      <= wdc_d;
      swr_trig_q <= swr_trig_d;
      busy_q     <= busy_d;
    end
  end

  // Flags pass through untouched, registered to meet output style
  logic [3:0] flags_q;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      flags_q <= 4'h0;
    end else begin
      flags_q <= flags_i;                                  // RQ13
    end
  end

  logic rst_out_q;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rst_out_q <= 1'b0;
    end else begin
      rst_out_q <= chip_rst;                               // RQ11
    end
  end

  assign program_counter_o = pc_q;
  assign stack_pointer_o   = sp_q;
  assign accumulator_o     = acc_q;
  assign acc_we_o          = acc_we_q;
  assign flags_o           = flags_q;
  assign gint_en_o         = gie_q;
  assign stack_o           = stk_q;
  assign busy_o            = busy_q;
  assign osc_stop_o        = osc_q;
  assign core_clk_gate_o   = gate_q;
  assign wdt_clear_o       = wdc_q;
  assign chip_rst_o        = rst_out_q;

  // Assertions
  sequence call_seq;
    go && instr_i.op == scx_pkg::SCX_OP_CALL;
  endsequence

  sequence ret_seq;
    go && instr_i.op == scx_pkg::SCX_OP_RET;
  endsequence

  call_push_a: assert property (@(posedge clk_sys_i) disable iff (rst_i || chip_rst) // RQ1
    call_seq |=> stk_q.wr && stk_q.wdata == $past(pc_q) + scx_pkg::PC_STEP && sp_q == $past(sp_q) + scx_pkg::SP_STEP)
    else $error("call push wrong");
  goto_load_a: assert property (@(posedge clk_sys_i) disable iff (rst_i || chip_rst) // RQ2
    go && instr_i.op == scx_pkg::SCX_OP_GOTO |=> pc_q == $past(instr_i.target))
    else $error("goto target wrong");
  retimm_acc_a: assert property (@(posedge clk_sys_i) disable iff (rst_i || chip_rst) // RQ3
    go && instr_i.op == scx_pkg::SCX_OP_RETIMM |=> acc_we_q && acc_q == $past(instr_i.imm))
    else $error("return value not loaded");
  ret_pop_a: assert property (@(posedge clk_sys_i) disable iff (rst_i || chip_rst) // RQ4
    ret_seq |=> sp_q == $past(sp_q) - scx_pkg::SP_STEP ##1 pc_q == $past(stack_rdata_i))
    else $error("return pop wrong");
  reti_gie_a: assert property (@(posedge clk_sys_i) disable iff (rst_i || chip_rst) // RQ5
    go && instr_i.op == scx_pkg::SCX_OP_RETI |=> ##1 gie_q)
    else $error("gie not set by reti");
  pcadd_sum_a: assert property (@(posedge clk_sys_i) disable iff (rst_i || chip_rst) // RQ6
    go && instr_i.op == scx_pkg::SCX_OP_PCADD |=> pc_q == $past(pc_q) + PC_W'($past(acc_i)))
    else $error("pcadd sum wrong");
  ei_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i || chip_rst) // RQ7
    go && instr_i.op == scx_pkg::SCX_OP_EI |=> gie_q)
    else $error("ei failed");
  di_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i || chip_rst) // RQ8
    go && instr_i.op == scx_pkg::SCX_OP_DI |=> !gie_q)
    else $error("di failed");
  halt_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i || chip_rst) // RQ14
    st_q == scx_pkg::SCX_ST_HALT && !wake_i |=> st_q == scx_pkg::SCX_ST_HALT && $stable(pc_q))
    else $error("halt left without wake");
  wdt_pulse_a: assert property (@(posedge clk_sys_i) disable iff (rst_i || chip_rst) // RQ12
    go && instr_i.op == scx_pkg::SCX_OP_WDRST |=> wdt_clear_o ##1 !wdt_clear_o)
    else $error("watchdog clear pulse wrong");
endmodule : scx_exec

/* File: test/scx_stack_model.sv */
// Behavioural stack RAM standing beside the executor.
// Assumes registered one-cycle requests on stack_i from the executor.
`timescale 1ns/1ps
module scx_stack_model (
  input  wire logic                        clk_sys_i,
  input  wire scx_pkg::scx_stack_t         stack_i,
  output logic [scx_pkg::PC_W-1:0]         rdata_o
);
  logic [scx_pkg::PC_W-1:0] mem_q [2**scx_pkg::SP_W];
  logic                     rd_q;
  logic [scx_pkg::SP_W-1:0] addr_q;
  logic [scx_pkg::PC_W-1:0] last_q = '0;

  // One word per saved address, slots two apart
  always @(posedge clk_sys_i) begin
    if (stack_i.wr) begin
      mem_q[stack_i.addr] <= stack_i.wdata;
    end
    rd_q   <= stack_i.rd;
    addr_q <= stack_i.addr;
    last_q <= rdata_o;
  end

  // Data held over the read cycle and the next; inverted junk otherwise
  always_comb begin
    if (stack_i.rd) begin
      rdata_o = mem_q[stack_i.addr];
    end else if (rd_q) begin
      rdata_o = mem_q[addr_q];
    end else begin
      rdata_o = ~last_q; // No stale value to lean on
    end
  end
endmodule : scx_stack_model

/* File: test/scx_exec_tb_top.sv */
// Self-checking bench for the system-control executor.
// Assumes the stack RAM model and a 50 MHz clock; pc and sp mirrored here.
`timescale 1ns/1ps
module scx_exec_tb_top;
  logic                clk_sys_i = 1'b0;
  logic                rst_i = 1'b1;
  logic                instr_valid_i = 1'b0;
  logic                wake_i = 1'b0;
  scx_pkg::scx_instr_t instr_i = '0;
  logic [7:0]          acc_i = 8'h00;
  logic [3:0]          flags_i = 4'h0;
  logic [11:0]         stack_rdata_i, program_counter_o;
  logic [7:0]          stack_pointer_o, accumulator_o;
  logic [3:0]          flags_o;
  logic                acc_we_o, gint_en_o, busy_o, osc_stop_o, core_clk_gate_o, wdt_clear_o, chip_rst_o;
  scx_pkg::scx_stack_t stack_o;
  int                  n_errors = 0;
  int                  num_checks = 0;
  logic [31:0]         lfsr_q = 32'h6B88;
  logic [11:0]         exp_pc = 12'h000;
  logic [7:0]          exp_sp = 8'h00;
  logic                exp_gie = 1'b0;
  logic [11:0]         exp_mem [256];
  logic [24:0]         note_q [$];
  event                res_ev;

  always #10 clk_sys_i = ~clk_sys_i;

  scx_exec scx_exec_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .acc_i(acc_i), .stack_rdata_i(stack_rdata_i), .wake_i(wake_i), .flags_i(flags_i),
    .program_counter_o(program_counter_o), .stack_pointer_o(stack_pointer_o), .accumulator_o(accumulator_o),
    .acc_we_o(acc_we_o), .flags_o(flags_o), .gint_en_o(gint_en_o), .stack_o(stack_o), .busy_o(busy_o),
    .osc_stop_o(osc_stop_o), .core_clk_gate_o(core_clk_gate_o), .wdt_clear_o(wdt_clear_o),
    .chip_rst_o(chip_rst_o));

  scx_stack_model scx_stack_model_inst (.clk_sys_i(clk_sys_i), .stack_i(stack_o), .rdata_o(stack_rdata_i));

  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic summarize();
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Bounded wait for the run state; a hang ends the run
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy_o !== 1'b0) begin
      if (n == 20) begin
        n_errors++;
        summarize();
      end
      @(negedge clk_sys_i);
      n++;
    end
  endtask : wait_idle

  // Issues one instruction, checks its first answer cycle, notes the end state
  task automatic exec(scx_pkg::scx_op_t op, logic [11:0] tgt);
    logic [11:0] p;
    logic [7:0]  s;
    logic        is_ret, is_halt;
    int          n;
    lfsr_q = lfsr_next(lfsr_q);
    p = exp_pc;
    s = exp_sp;
    is_ret = op inside {scx_pkg::SCX_OP_RET, scx_pkg::SCX_OP_RETI, scx_pkg::SCX_OP_RETIMM};
    is_halt = op inside {scx_pkg::SCX_OP_HALTSYS, scx_pkg::SCX_OP_HALTCPU};
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b1;
    instr_i <= '{op, tgt, lfsr_q[7:0]};
    acc_i <= lfsr_q[15:8];
    flags_i <= lfsr_q[19:16];
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b0;
    @(negedge clk_sys_i);
    chk("push", 32'(stack_o.wr), 32'(op == scx_pkg::SCX_OP_CALL));
    if (op == scx_pkg::SCX_OP_CALL) chk("push word", 32'({stack_o.addr, stack_o.wdata}), 32'({s, p + 12'h001}));
    chk("pop", 32'(stack_o.rd), 32'(is_ret));
    if (is_ret) chk("pop addr", 32'(stack_o.addr), 32'(s - 8'h02));
    chk("wdt clear", 32'(wdt_clear_o), 32'(op == scx_pkg::SCX_OP_WDRST));
    chk("clk gate", 32'(core_clk_gate_o), 32'(is_halt));
    chk("osc stop", 32'(osc_stop_o), 32'(op == scx_pkg::SCX_OP_HALTSYS));
    chk("acc we", 32'(acc_we_o), 32'(op == scx_pkg::SCX_OP_RETIMM));
    chk("busy", 32'(busy_o), 32'(is_ret || is_halt || op == scx_pkg::SCX_OP_SWRST));
    // Mirror of the documented effect
    case (op)
      scx_pkg::SCX_OP_CALL: begin
        exp_mem[s] = p + 12'h001;
        exp_pc = tgt;
        exp_sp = s + 8'h02;
      end
      scx_pkg::SCX_OP_GOTO: exp_pc = tgt;
      scx_pkg::SCX_OP_PCADD: exp_pc = p + {4'h0, lfsr_q[15:8]};
      scx_pkg::SCX_OP_SWRST: begin
        exp_pc = 12'h000;
        exp_sp = 8'h00;
        exp_gie = 1'b0;
      end
      default: begin
        exp_pc = p + 12'h001;
        if (op == scx_pkg::SCX_OP_EI) exp_gie = 1'b1;
        if (op == scx_pkg::SCX_OP_DI) exp_gie = 1'b0;
      end
    endcase
    if (is_ret) begin
      exp_sp = s - 8'h02;
      exp_pc = exp_mem[exp_sp];
      if (op == scx_pkg::SCX_OP_RETI) exp_gie = 1'b1;
    end
    // A jump offered while halted must be refused
    if (is_halt) begin
      repeat (3) begin
        @(posedge clk_sys_i);
        instr_valid_i <= 1'b1;
        instr_i.op <= scx_pkg::SCX_OP_GOTO;
      end
      @(posedge clk_sys_i);
      instr_valid_i <= 1'b0;
      wake_i <= 1'b1;
    end
    if (op == scx_pkg::SCX_OP_SWRST) begin
      n = 0;
      repeat (12) begin
        @(negedge clk_sys_i);
        if (chip_rst_o === 1'b1) n++;
      end
      chk("chip rst len", 32'(n), 32'(scx_pkg::SWRST_CYC));
      chk("acc after rst", 32'(accumulator_o), 32'h0);
    end
    wait_idle();
    if (is_halt) begin
      @(posedge clk_sys_i);
      wake_i <= 1'b0;
      @(negedge clk_sys_i);
      chk("clk gate off", 32'(core_clk_gate_o), 32'h0);
      chk("osc stop off", 32'(osc_stop_o), 32'h0);
    end
    if (op == scx_pkg::SCX_OP_RETIMM) chk("acc", 32'(accumulator_o), 32'(lfsr_q[7:0]));
    note_q.push_back({exp_pc, exp_sp, exp_gie, flags_i});
    ->res_ev;
  endtask : exec

  // Watcher: each noted result against what the outputs show
  initial begin
    logic [24:0] note;
    forever begin
      @(res_ev);
      while (note_q.size() > 0) begin
        note = note_q.pop_front();
        chk("state", 32'({program_counter_o, stack_pointer_o, gint_en_o, flags_o}), 32'(note));
      end
    end
  end

  // Main sequence: nested calls, every op except SCX_OP_NONE, unwinding, halts, reset
  initial begin
    scx_pkg::scx_op_t seq [15];
    seq = '{scx_pkg::SCX_OP_EI, scx_pkg::SCX_OP_DI, scx_pkg::SCX_OP_NOP, scx_pkg::SCX_OP_WDRST,
      scx_pkg::SCX_OP_PCADD, scx_pkg::SCX_OP_GOTO, scx_pkg::SCX_OP_RETI, scx_pkg::SCX_OP_RET,
      scx_pkg::SCX_OP_RETIMM, scx_pkg::SCX_OP_RET, scx_pkg::SCX_OP_HALTCPU, scx_pkg::SCX_OP_HALTSYS,
      scx_pkg::SCX_OP_EI, scx_pkg::SCX_OP_CALL, scx_pkg::SCX_OP_SWRST};
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(negedge clk_sys_i);
    note_q.push_back({exp_pc, exp_sp, exp_gie, flags_i});
    ->res_ev;
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      exec(scx_pkg::SCX_OP_CALL, lfsr_q[27:16]);
    end
    foreach (seq[k]) exec(seq[k], 12'hFFF);
    // Hardware reset in mid-run after interrupts were enabled
    exec(scx_pkg::SCX_OP_EI, 12'hFFF);
    @(posedge clk_sys_i);
    rst_i   <= 1'b1;
    flags_i <= 4'h0;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(negedge clk_sys_i);
    exp_pc  = 12'h000;
    exp_sp  = 8'h00;
    exp_gie = 1'b0;
    chk("chip rst idle", 32'(chip_rst_o), 32'h0);
    note_q.push_back({exp_pc, exp_sp, exp_gie, flags_i});
    ->res_ev;
    @(negedge clk_sys_i);
    summarize();
  end
endmodule : scx_exec_tb_top
